/* conv_seq_pkg.sv */
/*
 * constants for the converter sequencing and timing controller:
 * register offsets, field positions, reset values, timing figures.
 * assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package conv_seq_pkg;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
    localparam logic [7:0] OFS_CTRL_THREE = 8'h04;
    localparam logic [7:0] OFS_CHAN_SEL = 8'h08;
    localparam logic [7:0] OFS_SW_START = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_RESULT_A = 8'h18;
    localparam logic [7:0] OFS_RESULT_B = 8'h1C;
    localparam logic [7:0] OFS_STATE = 8'h20;
    // ==========================================================
    // field positions
    localparam int ACQ_LSB = 8;
    localparam int ACQ_W = 4;
    localparam int PAIRED_BIT = 0;
    localparam int CONT_BIT = 1;
    localparam int BANDGAP_HI_BIT = 7;
    localparam int BANDGAP_LO_BIT = 6;
    localparam int PWR_ON_BIT = 5;
    localparam int CLK_OFF_BIT = 4;
    localparam int CHAN_W = 4;
    localparam int RES_W = 12;
    localparam int IRQ_A = 0;
    localparam int IRQ_B = 1;
    localparam int IRQ_W = 2;
    // ==========================================================
    // converter clock and latencies, in converter clock periods; IRQ_DELAY in system clocks
    localparam int SYS_CLK_MHZ = 125;
    localparam int CONV_CLK_DIV = 10; // 12.5 MHz converter clock
    localparam int HALF_DIV = CONV_CLK_DIV / 2;
    localparam int TRIG_HALF_PERIODS = 5; // 2.5 periods
    localparam int FIRST_A_LAT = 4;
    localparam int FIRST_B_LAT = 5;
    localparam int SEQ_GAP_BASE = 2;
    localparam int SIM_GAP_BASE = 3;
    localparam int IRQ_DELAY = 2; // system clocks after result update
    localparam logic [31:0] RESET_CTRL = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        PWR_OPERATIONAL = 2'b00,
        PWR_DOWN_REF_ON = 2'b01,
        PWR_DOWN_REF_OFF = 2'b10,
        PWR_DOWN_CLK_OFF = 2'b11
    } power_cfg_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_SAMPLE = 2'b10
    } seq_state_t;
endpackage

/* conv_seq_ctrl.sv */
/*
 * converter sequencing and timing controller: start arbitration,
 * sample/hold pulse timing, pipelined result delivery, interrupts and
 * an AXI4-Lite register slave.
 * assumes start pins are asynchronous and need no debouncing, the
 * analog core holds its code from the sample instant until the result
 * is written, and the bus master waits for every answer.
 */
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
// Overview of operation
// R01: mode bit 0 sequential single channel, 1 simultaneous pair
// R02: sixteen inputs, two banks of eight, chosen by software
// R03: pwm event, software write or external pin starts conversion
// R04: sequential mode converts selected channel each pulse, may repeat
// R05: sequential input sampled at falling edge of sample/hold pulse
// R06: pulse width is one plus 4-bit acquisition field, control bits 8-11
// R07: sampling starts 2.5 converter clocks after trigger
// R08: sequential result after 4 clocks, later every 2 plus acquisition
// R09: simultaneous A after 4, B after 5, later every 3 plus acquisition
// R10: interrupt flags set few system clocks after result update
// R11: simultaneous mode samples both pair channels at one falling edge
// R12: software pairs only matching indices A0/B0 to A7/B7
// R13: 12-bit results through four-stage pipeline, overlapping samples
// R14: four power configurations from bandgap, reference, power, clock bits
// R15: software sets bandgap bits before converter power bit
// R16: software may set all power bits then wait settling time
// R17: result register written before interrupt logic is told
`timescale 1ns/1ns
module conv_seq_ctrl (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic pwm_event_source_i,
    input wire logic external_conversion_start_i,
    output logic converter_clock_o,
    output logic sample_hold_o,
    output logic [conv_seq_pkg::CHAN_W-1:0] mux_a_sel_o,
    output logic [conv_seq_pkg::CHAN_W-1:0] mux_b_sel_o,
    input wire logic [conv_seq_pkg::RES_W-1:0] core_code_a_i,
    input wire logic [conv_seq_pkg::RES_W-1:0] core_code_b_i,
    output logic bandgap_reference_power_o,
    output logic converter_power_on_o,
    output logic [1:0] power_cfg_o,
    output logic irq_o
);
    import conv_seq_pkg::*;

    localparam int PIPE = 8; // latency shift register depth

    // ==========================================================
    // state record
    // all remembered state, registered by one process
    typedef struct packed {
        logic [31:0] ctrl_one;
        logic [31:0] ctrl_three;
        logic [CHAN_W-1:0] chan;
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] mask;
        logic [RES_W-1:0] res_a;
        logic [RES_W-1:0] res_b;
        logic [3:0] div;
        logic cclk;
        seq_state_t st;
        logic [4:0] cnt;
        logic sh;
        logic [CHAN_W-1:0] held_chan;
        logic [PIPE-1:0] pipe_a;
        logic [PIPE-1:0] pipe_b;
        logic [IRQ_DELAY-1:0] irq_a_dly;
        logic [IRQ_DELAY-1:0] irq_b_dly;
        logic [1:0] pwm_sync;
        logic [1:0] ext_sync;
        logic pwm_old;
        logic ext_old;
        logic sw_req;
        // bus side
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t cur_ff;
    state_t nxt_s;

    logic paired;
    logic [3:0] acq;
    logic cclk_rise;
    logic cclk_fall;
    logic trig;
    logic do_write;
    logic do_read;
    logic [31:0] wmask;
    logic [4:0] gap_a;

    // ==========================================================
    // combinational next state
    always_comb begin
        nxt_s = cur_ff;
        paired = cur_ff.ctrl_one[PAIRED_BIT]; // see R01
        acq = cur_ff.ctrl_one[ACQ_LSB +: ACQ_W]; // see R06
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{cur_ff.w_strb[i]}};
        end

        // converter clock divider, stopped in the lowest power config;
        // the divider is held at zero so it restarts from a known phase
        cclk_rise = 1'b0;
        cclk_fall = 1'b0;
        if (cur_ff.ctrl_three[CLK_OFF_BIT]) begin // see R14
            nxt_s.div = 4'h0;
            nxt_s.cclk = 1'b0;
        end else if (cur_ff.div == 4'(HALF_DIV - 1)) begin
            nxt_s.div = 4'h0;
            nxt_s.cclk = ~cur_ff.cclk;
            cclk_rise = ~cur_ff.cclk;
            cclk_fall = cur_ff.cclk;
        end else begin
            nxt_s.div = cur_ff.div + 4'h1;
        end

        // start sources, pins synchronised then edge detected; the
        // edge detector resets low like the idle pins, so no false start
        nxt_s.pwm_sync = {cur_ff.pwm_sync[0], pwm_event_source_i};
        nxt_s.ext_sync = {cur_ff.ext_sync[0], external_conversion_start_i};
        nxt_s.pwm_old = cur_ff.pwm_sync[1];
        nxt_s.ext_old = cur_ff.ext_sync[1];
        trig = (cur_ff.pwm_sync[1] & ~cur_ff.pwm_old)
             | (cur_ff.ext_sync[1] & ~cur_ff.ext_old)
             | cur_ff.sw_req; // see R03
        // pin starts are dropped while converter power is off; a software start stays pending
        trig = trig & cur_ff.ctrl_three[PWR_ON_BIT]; // see R15
        // a start while busy is dropped, a pending software start too
        if (trig) begin
            nxt_s.sw_req = 1'b0;
        end

        // sample/hold sequencer, counts half periods of converter clock in the delay, whole periods in the pulse;
        // one marker bit per sample walks down pipe_a, and down pipe_b too in paired mode, so a
        // new sample may start while older ones are still on their way
        gap_a = 5'(paired ? SIM_GAP_BASE : SEQ_GAP_BASE) + 5'(acq);
        nxt_s.pipe_a = cur_ff.pipe_a;
        nxt_s.pipe_b = cur_ff.pipe_b;
        if (cclk_rise) begin
            nxt_s.pipe_a = {1'b0, cur_ff.pipe_a[PIPE-1:1]}; // see R13
            nxt_s.pipe_b = {1'b0, cur_ff.pipe_b[PIPE-1:1]};
        end
        // sequencer: idle, trigger delay, then the sample/hold pulse
        unique case (cur_ff.st)
            ST_IDLE: begin
                if (trig) begin
                    nxt_s.st = ST_DELAY;
                    nxt_s.cnt = 5'(TRIG_HALF_PERIODS);
                end
            end
            ST_DELAY: begin
                // count half periods down to one, then wait for a rise so
                // the pulse always spans whole converter clocks
                if ((cclk_rise | cclk_fall) & (cur_ff.cnt != 5'h1)) begin
                    nxt_s.cnt = cur_ff.cnt - 5'h1;
                end
                if (cclk_rise & (cur_ff.cnt == 5'h1)) begin // see R07
                    nxt_s.st = ST_SAMPLE;
                    nxt_s.sh = 1'b1;
                    nxt_s.held_chan = cur_ff.chan;
                    nxt_s.cnt = 5'(acq) + 5'h1; // see R06
                end
            end
            ST_SAMPLE: begin
                if (cclk_rise) begin
                    nxt_s.cnt = cur_ff.cnt - 5'h1;
                    if (cur_ff.cnt == 5'h1) begin
                        // falling edge of pulse: sample taken
                        nxt_s.sh = 1'b0; // see R05 R11
                        nxt_s.pipe_a[FIRST_A_LAT-1] = 1'b1; // see R08 R09
                        nxt_s.pipe_b[FIRST_B_LAT-1] = paired; // see R09
                        // continuous mode re-arms without a new start
                        if (cur_ff.ctrl_one[CONT_BIT]) begin // see R04
                            // idle gap in half periods, ends on a rise
                            nxt_s.cnt = 5'((gap_a - 5'(acq) - 5'h1) << 1);
                            nxt_s.st = ST_DELAY;
                        end else begin
                            nxt_s.st = ST_IDLE;
                        end
                    end
                end
            end
            default: nxt_s.st = ST_IDLE;
        endcase

        // results written first, flags follow a few system clocks later;
        // the core code is taken at the edge that writes the result
        nxt_s.irq_a_dly = {cur_ff.irq_a_dly[IRQ_DELAY-2:0], 1'b0};
        nxt_s.irq_b_dly = {cur_ff.irq_b_dly[IRQ_DELAY-2:0], 1'b0};
        if (cclk_rise & cur_ff.pipe_a[0]) begin
            nxt_s.res_a = core_code_a_i; // see R17
            nxt_s.irq_a_dly[0] = 1'b1;
        end
        if (cclk_rise & cur_ff.pipe_b[0]) begin
            nxt_s.res_b = core_code_b_i; // see R17
            nxt_s.irq_b_dly[0] = 1'b1;
        end

        // ------------------------------------------------------
        // AXI4-Lite slave, both channels accepted in either order; the
        // write is applied once both are held, and a standing bvalid
        // blocks new items until the master takes the response
        if (s_axi_awvalid_i & ~cur_ff.aw_got & ~cur_ff.bvalid) begin
            nxt_s.aw_got = 1'b1;
            nxt_s.aw_addr = s_axi_awaddr_i[7:0];
        end
        if (s_axi_wvalid_i & ~cur_ff.w_got & ~cur_ff.bvalid) begin
            nxt_s.w_got = 1'b1;
            nxt_s.w_data = s_axi_wdata_i;
            nxt_s.w_strb = s_axi_wstrb_i;
        end
        do_write = cur_ff.aw_got & cur_ff.w_got & ~cur_ff.bvalid;
        nxt_s.status = cur_ff.status;
        if (do_write) begin
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = RESP_OKAY;
            unique case (cur_ff.aw_addr)
                OFS_CTRL_ONE: nxt_s.ctrl_one = (cur_ff.ctrl_one & ~wmask)
                    | (cur_ff.w_data & wmask);
                OFS_CTRL_THREE: nxt_s.ctrl_three =
                    (cur_ff.ctrl_three & ~wmask) | (cur_ff.w_data & wmask);
                OFS_CHAN_SEL: if (cur_ff.w_strb[0]) begin
                    nxt_s.chan = cur_ff.w_data[CHAN_W-1:0]; // see R02 R12
                end
                OFS_SW_START: if (cur_ff.w_strb[0] & cur_ff.w_data[0]) begin
                    nxt_s.sw_req = 1'b1;
                end
                OFS_IRQ_STATUS: if (cur_ff.w_strb[0]) begin
                    nxt_s.status = cur_ff.status
                        & ~cur_ff.w_data[IRQ_W-1:0];
                end
                OFS_IRQ_MASK: if (cur_ff.w_strb[0]) begin
                    nxt_s.mask = cur_ff.w_data[IRQ_W-1:0];
                end
                OFS_RESULT_A, OFS_RESULT_B, OFS_STATE: ;
                default: nxt_s.bresp = RESP_SLVERR;
            endcase
        end
        if (cur_ff.bvalid & s_axi_bready_i) begin
            nxt_s.bvalid = 1'b0;
        end

        // set wins over software clear, so an event that lands in the
        // clearing cycle is never lost
        if (cur_ff.irq_a_dly[IRQ_DELAY-1]) begin
            nxt_s.status[IRQ_A] = 1'b1; // see R10
        end
        if (cur_ff.irq_b_dly[IRQ_DELAY-1]) begin
            nxt_s.status[IRQ_B] = 1'b1; // see R10
        end

        // reads answer one cycle after the address is taken; unmapped
        // addresses return zero with an error response
        do_read = s_axi_arvalid_i & ~cur_ff.rvalid;
        if (do_read) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp = RESP_OKAY;
            nxt_s.rdata = 32'h0000_0000;
            unique case (s_axi_araddr_i[7:0])
                OFS_CTRL_ONE: nxt_s.rdata = cur_ff.ctrl_one;
                OFS_CTRL_THREE: nxt_s.rdata = cur_ff.ctrl_three;
                OFS_CHAN_SEL: nxt_s.rdata[CHAN_W-1:0] = cur_ff.chan;
                OFS_SW_START: nxt_s.rdata[0] = cur_ff.sw_req;
                OFS_IRQ_STATUS: nxt_s.rdata[IRQ_W-1:0] = cur_ff.status;
                OFS_IRQ_MASK: nxt_s.rdata[IRQ_W-1:0] = cur_ff.mask;
                OFS_RESULT_A: nxt_s.rdata[RES_W-1:0] = cur_ff.res_a;
                OFS_RESULT_B: nxt_s.rdata[RES_W-1:0] = cur_ff.res_b;
                OFS_STATE: nxt_s.rdata[2:0] = {cur_ff.sh, cur_ff.st};
                default: nxt_s.rresp = RESP_SLVERR;
            endcase
        end
        if (cur_ff.rvalid & s_axi_rready_i) begin
            nxt_s.rvalid = 1'b0;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cur_ff <= '0;
            cur_ff.ctrl_one <= RESET_CTRL;
            cur_ff.ctrl_three <= RESET_CTRL;
            cur_ff.st <= ST_IDLE;
        end else begin
            cur_ff <= nxt_s;
        end
    end

    // ==========================================================
    // outputs
    // ready signals come straight from the state, so a request can be
    // taken in its first cycle
    assign s_axi_awready_o = ~cur_ff.aw_got & ~cur_ff.bvalid;
    assign s_axi_wready_o = ~cur_ff.w_got & ~cur_ff.bvalid;
    assign s_axi_bvalid_o = cur_ff.bvalid;
    assign s_axi_bresp_o = cur_ff.bresp;
    assign s_axi_arready_o = ~cur_ff.rvalid;
    assign s_axi_rvalid_o = cur_ff.rvalid;
    assign s_axi_rdata_o = cur_ff.rdata;
    assign s_axi_rresp_o = cur_ff.rresp;
    assign converter_clock_o = cur_ff.cclk;
    assign sample_hold_o = cur_ff.sh;
    // pair uses same index on both banks, sequential uses chan[3] as bank
    assign mux_a_sel_o = cur_ff.held_chan;
    assign mux_b_sel_o = {1'b1, cur_ff.held_chan[CHAN_W-2:0]}; // see R11
    // powered only when both bandgap and reference bits are set
    assign bandgap_reference_power_o = cur_ff.ctrl_three[BANDGAP_HI_BIT]
        & cur_ff.ctrl_three[BANDGAP_LO_BIT]; // see R14 R16
    assign converter_power_on_o = cur_ff.ctrl_three[PWR_ON_BIT];
    // power configuration reported from the bits, see R14
    assign power_cfg_o = ~cur_ff.ctrl_three[PWR_ON_BIT]
        ? (cur_ff.ctrl_three[CLK_OFF_BIT] ? PWR_DOWN_CLK_OFF
        : (bandgap_reference_power_o ? PWR_DOWN_REF_ON : PWR_DOWN_REF_OFF))
        : PWR_OPERATIONAL;
    assign irq_o = |(cur_ff.status & cur_ff.mask);
endmodule

/* conv_core_model.sv */
/* analog core stand-in: one code per channel, taken at each sample
   instant. assumes the controller drives both mux selects. */
`timescale 1ns/1ns
module conv_core_model (
    input wire logic clk_i,
    input wire logic sample_hold_i,
    input wire logic [3:0] mux_a_sel_i,
    input wire logic [3:0] mux_b_sel_i,
    output logic [11:0] code_a_o = 12'h000,
    output logic [11:0] code_b_o = 12'h000
);
    logic sh_ff = 1'b0;
    // both banks taken at the same falling edge, then held
    always @(posedge clk_i) begin
        sh_ff <= sample_hold_i;
        if (sh_ff && !sample_hold_i) begin
            code_a_o <= {8'hA0, mux_a_sel_i};
            code_b_o <= {8'hB0, mux_b_sel_i};
        end
    end
endmodule

/* conv_seq_ctrl_chk.sv */
/* port checker for the sequencing controller, bound at the foot.
   assumes one clock and a sync active-high reset. */
`timescale 1ns/1ns
module conv_seq_ctrl_chk import conv_seq_pkg::*; (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic converter_clock_o,
    input wire logic sample_hold_o,
    input wire logic [conv_seq_pkg::CHAN_W-1:0] mux_a_sel_o,
    input wire logic [conv_seq_pkg::CHAN_W-1:0] mux_b_sel_o,
    input wire logic bandgap_reference_power_o,
    input wire logic converter_power_on_o,
    input wire logic [1:0] power_cfg_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic [7:0] sh_cnt_ff;
    logic clk_off;
    // high cycles of the current pulse
    always_ff @(posedge clk_i)
        sh_cnt_ff <= (sys_rst_i || !sample_hold_o) ? 8'h00 : sh_cnt_ff + 8'h01;
    assign clk_off = power_cfg_o == PWR_DOWN_CLK_OFF;
    // ============================================================
    // assertions
    property p_aw_busy; s_axi_bvalid_o |-> !s_axi_awready_o; endproperty
    a_aw_busy: assert property (p_aw_busy) else $error("aw open");
    property p_ar_busy; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
    a_ar_busy: assert property (p_ar_busy) else $error("ar open");
    property p_r_ans;
        s_axi_arvalid_i && s_axi_arready_o |-> ##[1:2] s_axi_rvalid_o;
    endproperty
    a_r_ans: assert property (p_r_ans) else $error("no read data");
    property p_width; $fell(sample_hold_o) |-> sh_cnt_ff % 8'h0A == 8'h00
        && sh_cnt_ff >= 8'h0A && sh_cnt_ff <= 8'hA0; endproperty
    a_width: assert property (p_width)
        else $error("pulse width off");
    property p_cclk; $changed(converter_clock_o) && !clk_off |=>
        ($stable(converter_clock_o) || clk_off) [*4]; endproperty
    a_cclk: assert property (p_cclk) else $error("cclk phase");
    property p_pair; sample_hold_o [*2] |->
        mux_b_sel_o == {1'b1, mux_a_sel_o[2:0]}; endproperty
    a_pair: assert property (p_pair) else $error("pair index");
    property p_hold; sample_hold_o [*3] |-> $stable(mux_a_sel_o); endproperty
    a_hold: assert property (p_hold) else $error("mux moved");
    property p_pwr; bandgap_reference_power_o && converter_power_on_o
        |-> power_cfg_o == PWR_OPERATIONAL; endproperty
    a_pwr: assert property (p_pwr) else $error("power cfg");
    c_fall: cover property ($fell(sample_hold_o));
    c_read: cover property (s_axi_rvalid_o);
    c_off: cover property (clk_off);
endmodule
bind conv_seq_ctrl conv_seq_ctrl_chk u_conv_seq_ctrl_chk (.*);

/* adc_sequencing_timing_control_test.sv */
/* bench for the sequencing controller: axi4-lite tasks, start pins
   and pulse timing. assumes the core model and checker come first. */
`timescale 1ns/1ns
module adc_sequencing_timing_control_test;
    import conv_seq_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [31:0] s_axi_awaddr_i = 32'h0, s_axi_araddr_i = 32'h0;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1;
    logic pwm_event_source_i = 1'b0, external_conversion_start_i = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic s_axi_arready_o, s_axi_rvalid_o, converter_clock_o;
    logic sample_hold_o, irq_o, bandgap_reference_power_o;
    logic converter_power_on_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, power_cfg_o, rr, br;
    logic [31:0] s_axi_rdata_o, rv;
    logic [3:0] mux_a_sel_o, mux_b_sel_o;
    logic [11:0] core_code_a_i, core_code_b_i;
    int miscompares = 0, check_count = 0, n, a, b;
    // free running system clock
    initial forever #4 clk_i = ~clk_i;
    conv_seq_ctrl u_conv_seq_ctrl (.*);
    conv_core_model u_conv_core_model (.clk_i, .sample_hold_i(sample_hold_o),
        .mux_a_sel_i(mux_a_sel_o), .mux_b_sel_i(mux_b_sel_o),
        .code_a_o(core_code_a_i), .code_b_o(core_code_b_i));
    // ============================================================
    // reporting
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_rng(input int g, input int lo, input int hi);
        check_count++;
        if (g < lo || g > hi) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
        end
    endtask
    // ============================================================
    // bus cycles and bounded waits
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        int k;
        k = 0;
        s_axi_awaddr_i <= {24'h0, ad};
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        do begin
            @(posedge clk_i);
            k++;
            if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
        end while (s_axi_bvalid_o !== 1'b1 && k < 50);
        br = s_axi_bresp_o;
        if (k >= 50) miscompares++;
        if (k >= 50) print_verdict();
    endtask
    task automatic rd(input logic [7:0] ad);
        int k;
        k = 0;
        s_axi_araddr_i <= {24'h0, ad};
        s_axi_arvalid_i <= 1'b1;
        do begin
            @(posedge clk_i);
            k++;
            if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
        end while (s_axi_rvalid_o !== 1'b1 && k < 50);
        rv = s_axi_rdata_o;
        rr = s_axi_rresp_o;
        if (k >= 50) miscompares++;
        if (k >= 50) print_verdict();
    endtask
    task automatic wt(input bit irq, input logic v, output int k);
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while ((irq ? irq_o : sample_hold_o) !== v && k < 400);
        if (k >= 400) miscompares++;
        if (k >= 400) print_verdict();
    endtask
    // ============================================================
    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(OFS_CTRL_ONE);
        chk(rv, RESET_CTRL);
        rd(8'h40);
        chk(rv, 32'h0);
        chk(32'(rr), 32'(RESP_SLVERR));
        wr(8'h40, 32'h1);
        chk(32'(br), 32'(RESP_SLVERR));
        wr(OFS_CTRL_THREE, 32'hC0);
        chk(power_cfg_o, PWR_DOWN_REF_ON);
        wr(OFS_CTRL_THREE, 32'hE0);
        chk({bandgap_reference_power_o, converter_power_on_o}, 2'h3);
        chk(power_cfg_o, PWR_OPERATIONAL);
        wr(OFS_IRQ_MASK, 32'h1);
        chk(32'(br), 32'(RESP_OKAY));
        // single shots from each start source
        for (int s = 0; s < 3; s++) begin
            wr(OFS_CHAN_SEL, 32'h5 + 4 * s);
            wr(OFS_CTRL_ONE, 32'h300);
            if (s == 0) wr(OFS_SW_START, 32'h1);
            else if (s == 1) pwm_event_source_i <= 1'b1;
            else external_conversion_start_i <= 1'b1;
            wt(0, 1'b1, n);
            chk_rng(n, s ? 25 : 22, s ? 34 : 31);
            pwm_event_source_i <= 1'b0;
            external_conversion_start_i <= 1'b0;
            wt(0, 1'b0, n);
            chk_rng(n, 40, 40);
            chk(mux_a_sel_o, 32'h5 + 4 * s);
            wt(1, 1'b1, n);
            chk_rng(n, 38 + IRQ_DELAY, 42 + IRQ_DELAY);
            rd(OFS_RESULT_A);
            chk(rv, 32'hA05 + 4 * s);
            wr(OFS_IRQ_STATUS, 32'h1);
            chk(irq_o, 1'b0);
        end
        // continuous paired then sequential, interrupt masked
        wr(OFS_IRQ_MASK, 32'h0);
        wr(OFS_CHAN_SEL, 32'h3);
        for (int c = 0; c < 2; c++) begin
            wr(OFS_CTRL_ONE, c ? 32'hF02 : 32'h3);
            if (c == 0) wr(OFS_SW_START, 32'h1);
            wt(0, 1'b1, n);
            wt(0, 1'b0, n);
            wt(0, 1'b1, n);
            wt(0, 1'b0, a);
            wt(0, 1'b1, b);
            chk_rng(a, c ? 160 : 10, c ? 160 : 10);
            chk_rng(a + b, c ? 170 : 30, c ? 170 : 30);
        end
        wr(OFS_CTRL_ONE, 32'hF00);
        repeat (300) @(posedge clk_i);
        chk(irq_o, 1'b0);
        rd(OFS_IRQ_STATUS);
        chk(rv, 32'h3);
        rd(OFS_RESULT_B);
        chk(rv, 32'hB0B);
        rd(OFS_RESULT_A);
        chk(rv, 32'hA03);
        chk(32'(mux_b_sel_o), 32'hB);
        rd(OFS_STATE);
        chk(rv, 32'h0);
        wr(OFS_IRQ_MASK, 32'h2);
        chk(irq_o, 1'b1);
        wr(OFS_IRQ_STATUS, 32'h2);
        chk(irq_o, 1'b0);
        rd(OFS_IRQ_STATUS);
        chk(rv, 32'h1);
        // power down configurations
        wr(OFS_CTRL_THREE, 32'h00);
        chk(power_cfg_o, PWR_DOWN_REF_OFF);
        wr(OFS_CTRL_THREE, 32'h10);
        repeat (12) @(posedge clk_i);
        chk({power_cfg_o, converter_clock_o}, {PWR_DOWN_CLK_OFF, 1'b0});
        wr(OFS_CTRL_THREE, 32'hE0);
        chk(power_cfg_o, PWR_OPERATIONAL);
        print_verdict();
    end
endmodule
